// ===== rtl/alert_timing_consts.svh
// Timing constants for the alert, leveling, termination and refresh block
`ifndef ALERT_TIMING_CONSTS_SVH
`define ALERT_TIMING_CONSTS_SVH
`define CLK_PS             20000
`define LINK_PS            80000
`define ASYNC_TERM_MIN_PS  1000
`define ASYNC_TERM_CYC     ((`ASYNC_TERM_MIN_PS + `CLK_PS - 1) / `CLK_PS)
`define DYN_TERM_MIN_TENTH 3
`define DYN_TERM_CYC       ((`DYN_TERM_MIN_TENTH + 9) / 10)
`define LEVEL_FIRST_WAIT   40
`define LEVEL_EN_WAIT      25
`define PAR_LAT            4
`define PAR_PW_MIN         48
`define PAR_PW_MAX         96
`define PAR_PW             ((`PAR_PW_MIN + `PAR_PW_MAX) / 2)
`define CRC_PW_MIN         6
`define CRC_PW_MAX         10
`define CRC_PW             ((`CRC_PW_MIN + `CRC_PW_MAX) / 2)
`define REF_NORM_NS        350
`define REF_DBL_NS         260
`define REF_QUAD_NS        160
`define SR_ABORT_EXTRA_NS  10
`define NS_CYC(ns)         (((ns) * 1000 + `CLK_PS - 1) / `CLK_PS)
`endif

// ===== rtl/alert_timing_pkg.sv
// Types shared by the alert, leveling, termination and refresh block
package alert_timing_pkg;
    typedef enum logic [1:0] {REF_NORMAL, REF_DOUBLE, REF_QUAD, REF_RSVD} ref_mode_t;
    typedef enum logic [1:0] {LV_OFF, LV_WAIT, LV_ACT} lv_state_t;
    typedef struct packed {
        logic par;
        logic crc;
    } err_src_t;
endpackage : alert_timing_pkg

// ===== rtl/alert_timing_core.sv
// Alert generation, write leveling feedback, termination and refresh timing
`timescale 1ns/1ps
`default_nettype none
`include "alert_timing_consts.svh"
module alert_timing_core
    import alert_timing_pkg::*;
(
    input  wire logic      CLOCK_I,
    input  wire logic      RST_I,
    input  wire logic      LINK_CK_I,
    input  wire logic      PAR_ERR_I,
    input  wire logic      CRC_ERR_I,
    input  wire logic      LEVEL_EN_I,
    input  wire logic      DQS_I,
    input  wire logic      CK_LVL_I,
    input  wire logic      TERM_REQ_I,
    input  wire logic      PD_FROZEN_I,
    input  wire logic      TERM_WR_REQ_I,
    input  wire logic      REF_CMD_I,
    input  wire logic      SR_ABORT_I,
    input  wire ref_mode_t REF_MODE_I,
    output logic           ALERT_N_O,
    output logic           CMD_HOLD_O,
    output logic           LEVEL_FB_O,
    output logic           LEVEL_FB_OE_O,
    output logic           TERM_ON_O,
    output logic           TERM_WR_O,
    output logic           REF_BUSY_O,
    output err_src_t       ERR_SRC_O
);
    // Link side synchronisers: s1 feeds s2 only, s3 is for edges
    logic [4:0] lk_s1_q;
    logic [4:0] lk_s2_q;
    logic [4:0] lk_s3_q;
    always_ff @(posedge LINK_CK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            lk_s1_q <= 5'h00;
            lk_s2_q <= 5'h00;
            lk_s3_q <= 5'h00;
        end
        else
        begin
            lk_s1_q <= {PAR_ERR_I, CRC_ERR_I, LEVEL_EN_I, DQS_I, CK_LVL_I};
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
        end
    end

    logic par_ev;
    logic crc_ev;
    logic str_rise;
    logic lv_en;
    assign par_ev   = lk_s2_q[4] & ~lk_s3_q[4];
    assign crc_ev   = lk_s2_q[3] & ~lk_s3_q[3];
    assign lv_en    = lk_s2_q[2];
    assign str_rise = lk_s2_q[1] & ~lk_s3_q[1];

    // Alert path on the link clock
    logic [2:0] par_dly_q;
    logic [2:0] par_dly_d;
    logic [7:0] par_cnt_q;
    logic [7:0] par_cnt_d;
    logic [3:0] crc_cnt_q;
    logic [3:0] crc_cnt_d;
    logic [2:0] win_q;
    logic [2:0] win_d;
    logic       hold_q;
    logic       hold_d;
    logic       alert_n_q;
    logic       alert_n_d;
    logic       par_on_q;
    logic       par_on_d;
    logic       crc_on_q;
    logic       crc_on_d;
    always_comb
    begin
        par_dly_d = par_dly_q;
        par_cnt_d = par_cnt_q;
        crc_cnt_d = crc_cnt_q;
        win_d     = win_q;
        // A second parity error during a pending alert is folded into it
        if (par_dly_q != 3'h0)
        begin
            par_dly_d = par_dly_q - 3'h1;
            if (par_dly_q == 3'h1)
                par_cnt_d = 8'(`PAR_PW);
        end
        else if (par_cnt_q != 8'h00)
            par_cnt_d = par_cnt_q - 8'h01;
        else if (par_ev)
            par_dly_d = 3'(`PAR_LAT - 1);
        if (par_ev)
            win_d = 3'(`PAR_LAT);
        else if (win_q != 3'h0)
            win_d = win_q - 3'h1;
        hold_d = (win_d != 3'h0);
        if (crc_ev)
            crc_cnt_d = 4'(`CRC_PW);
        else if (crc_cnt_q != 4'h0)
            crc_cnt_d = crc_cnt_q - 4'h1;
        // Shared low-active line; each source keeps its own window
        // Registered so the crossing never sees comparator glitches
        par_on_d  = (par_cnt_d != 8'h00);
        crc_on_d  = (crc_cnt_d != 4'h0);
        alert_n_d = ~(par_on_d | crc_on_d);
    end
    always_ff @(posedge LINK_CK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            par_dly_q <= 3'h0;
            par_cnt_q <= 8'h00;
            crc_cnt_q <= 4'h0;
            win_q     <= 3'h0;
            hold_q    <= 1'b0;
            alert_n_q <= 1'b1;
            par_on_q  <= 1'b0;
            crc_on_q  <= 1'b0;
        end
        else
        begin
            par_dly_q <= par_dly_d;
            par_cnt_q <= par_cnt_d;
            crc_cnt_q <= crc_cnt_d;
            win_q     <= win_d;
            hold_q    <= hold_d;
            alert_n_q <= alert_n_d;
            par_on_q  <= par_on_d;
            crc_on_q  <= crc_on_d;
        end
    end
    assign ALERT_N_O  = alert_n_q;
    assign CMD_HOLD_O = hold_q;

    // Write leveling: strobes before the wait ends are ignored
    lv_state_t  lv_st_q;
    lv_state_t  lv_st_d;
    logic [5:0] lv_cnt_q;
    logic [5:0] lv_cnt_d;
    logic       fb_q;
    logic       fb_d;
    logic       fb_oe_q;
    logic       fb_oe_d;
    always_comb
    begin
        lv_st_d  = lv_st_q;
        lv_cnt_d = lv_cnt_q;
        fb_d     = fb_q;
        case (lv_st_q)
            LV_OFF:
            begin
                lv_cnt_d = 6'h00;
                if (lv_en)
                    lv_st_d = LV_WAIT;
            end
            LV_WAIT:
            begin
                lv_cnt_d = lv_cnt_q + 6'h01;
                if (lv_cnt_q == 6'(`LEVEL_FIRST_WAIT - 1))
                    lv_st_d = LV_ACT;
            end
            LV_ACT:
            begin
                if (str_rise)
                    fb_d = lk_s2_q[0];
            end
            default:
                lv_st_d = LV_OFF;
        endcase
        if (!lv_en)
            lv_st_d = LV_OFF;
        fb_oe_d = lv_en & ((lv_st_q == LV_ACT) |
                  (lv_cnt_q >= 6'(`LEVEL_EN_WAIT)));
    end
    always_ff @(posedge LINK_CK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            lv_st_q  <= LV_OFF;
            lv_cnt_q <= 6'h00;
            fb_q     <= 1'b0;
            fb_oe_q  <= 1'b0;
        end
        else
        begin
            lv_st_q  <= lv_st_d;
            lv_cnt_q <= lv_cnt_d;
            fb_q     <= fb_d;
            fb_oe_q  <= fb_oe_d;
        end
    end
    assign LEVEL_FB_O    = fb_q;
    assign LEVEL_FB_OE_O = fb_oe_q;

    // System side synchronisers, also carrying alert source levels
    logic [8:0] sy_s1_q;
    logic [8:0] sy_s2_q;
    logic [8:0] sy_s3_q;
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sy_s1_q <= 9'h000;
            sy_s2_q <= 9'h000;
            sy_s3_q <= 9'h000;
        end
        else
        begin
            // Mode must settle before the refresh edge that samples it
            sy_s1_q <= {par_on_q, crc_on_q, TERM_REQ_I,
                        PD_FROZEN_I, TERM_WR_REQ_I, REF_CMD_I, SR_ABORT_I,
                        REF_MODE_I};
            sy_s2_q <= sy_s1_q;
            sy_s3_q <= sy_s2_q;
        end
    end
    // Source flags let the controller tell parity from checksum alerts
    assign ERR_SRC_O = '{par: sy_s2_q[8], crc: sy_s2_q[7]};

    logic      t_req;
    logic      t_pd;
    logic      t_wr;
    logic      ref_rise;
    logic      abort_rise;
    ref_mode_t r_mode;
    assign t_req      = sy_s2_q[6];
    assign t_pd       = sy_s2_q[5];
    assign t_wr       = sy_s2_q[4];
    assign ref_rise   = sy_s2_q[3] & ~sy_s3_q[3];
    assign abort_rise = sy_s2_q[2] & ~sy_s3_q[2];
    assign r_mode     = ref_mode_t'(sy_s2_q[1:0]);

    // Termination: both paths settle within one system clock
    logic       term_on_q;
    logic       term_on_d;
    logic       term_wr_q;
    logic       term_wr_d;
    logic [1:0] tcnt_q;
    logic [1:0] tcnt_d;
    logic [7:0] rcnt_q;
    logic [7:0] rcnt_d;
    logic       rbusy_q;
    logic       rbusy_d;
    always_comb
    begin
        term_on_d = term_on_q;
        term_wr_d = term_wr_q;
        tcnt_d    = 2'h0;
        if (t_pd)
        begin
            // Write termination is not used while the delay loop is frozen
            term_wr_d = 1'b0;
            if (t_req != term_on_q)
            begin
                tcnt_d = tcnt_q + 2'h1;
                if (tcnt_q == 2'(`ASYNC_TERM_CYC - 1))
                begin
                    term_on_d = t_req;
                    tcnt_d    = 2'h0;
                end
            end
        end
        else if ((t_req != term_on_q) || (t_wr != term_wr_q))
        begin
            tcnt_d = tcnt_q + 2'h1;
            if (tcnt_q == 2'(`DYN_TERM_CYC - 1))
            begin
                term_on_d = t_req;
                term_wr_d = t_wr;
                tcnt_d    = 2'h0;
            end
        end
        // Refresh busy window; a new refresh restarts the full spacing
        rcnt_d = (rcnt_q != 8'h00) ? rcnt_q - 8'h01 : 8'h00;
        if (ref_rise)
        begin
            case (r_mode)
                REF_NORMAL: rcnt_d = 8'(`NS_CYC(`REF_NORM_NS));
                REF_DOUBLE: rcnt_d = 8'(`NS_CYC(`REF_DBL_NS));
                REF_QUAD:   rcnt_d = 8'(`NS_CYC(`REF_QUAD_NS));
                default:    rcnt_d = 8'(`NS_CYC(`REF_NORM_NS));
            endcase
        end
        else if (abort_rise)
            rcnt_d = 8'(`NS_CYC(`REF_QUAD_NS + `SR_ABORT_EXTRA_NS));
        rbusy_d = (rcnt_d != 8'h00);
    end
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            term_on_q <= 1'b0;
            term_wr_q <= 1'b0;
            tcnt_q    <= 2'h0;
            rcnt_q    <= 8'h00;
            rbusy_q   <= 1'b0;
        end
        else
        begin
            term_on_q <= term_on_d;
            term_wr_q <= term_wr_d;
            tcnt_q    <= tcnt_d;
            rcnt_q    <= rcnt_d;
            rbusy_q   <= rbusy_d;
        end
    end
    assign TERM_ON_O  = term_on_q;
    assign TERM_WR_O  = term_wr_q;
    assign REF_BUSY_O = rbusy_q;

    // Checks on the behaviour above
    logic [7:0] par_len_q;
    always_ff @(posedge LINK_CK_I or posedge RST_I)
    begin
        if (RST_I)
            par_len_q <= 8'h00;
        else
            par_len_q <= (par_cnt_q != 8'h00) ? par_len_q + 8'h01 : 8'h00;
    end

    property p_par_alert_delay;
        @(posedge LINK_CK_I) disable iff (RST_I)
        par_ev && par_dly_q == 3'h0 && par_cnt_q == 8'h00 |-> ##4 !alert_n_q;
    endproperty
    a_par_alert_delay: assert property (p_par_alert_delay)
        else $error("parity alert not asserted after parity latency");

    property p_par_width;
        @(posedge LINK_CK_I) disable iff (RST_I)
        par_cnt_q != 8'h00 && par_cnt_d == 8'h00 |->
            par_len_q >= 8'(`PAR_PW_MIN - 1) && par_len_q <= 8'(`PAR_PW_MAX - 1);
    endproperty
    a_par_width: assert property (p_par_width)
        else $error("parity alert width out of range");

    property p_par_window;
        @(posedge LINK_CK_I) disable iff (RST_I)
        par_ev |=> hold_q [*4];
    endproperty
    a_par_window: assert property (p_par_window)
        else $error("command hold window too short");

    property p_crc_alert;
        @(posedge LINK_CK_I) disable iff (RST_I)
        crc_ev |=> !alert_n_q [*6];
    endproperty
    a_crc_alert: assert property (p_crc_alert)
        else $error("checksum alert late or too short");

    property p_crc_end;
        @(posedge LINK_CK_I) disable iff (RST_I)
        $fell(crc_cnt_q != 4'h0) |-> $past(crc_cnt_q) == 4'h1 && !$past(crc_ev);
    endproperty
    a_crc_end: assert property (p_crc_end)
        else $error("checksum alert ended early");

    property p_alert_src;
        @(posedge LINK_CK_I) disable iff (RST_I)
        !alert_n_q |-> par_cnt_q != 8'h00 || crc_cnt_q != 4'h0;
    endproperty
    a_alert_src: assert property (p_alert_src)
        else $error("alert low without a source");

    property p_lv_wait;
        @(posedge LINK_CK_I) disable iff (RST_I)
        $rose(lv_st_q == LV_ACT) |-> $past(lv_cnt_q) == 6'(`LEVEL_FIRST_WAIT - 1);
    endproperty
    a_lv_wait: assert property (p_lv_wait)
        else $error("leveling active before wait ended");

    property p_lv_oe;
        @(posedge LINK_CK_I) disable iff (RST_I)
        fb_oe_q |-> $past(lv_en) && ($past(lv_st_q) == LV_ACT ||
                    $past(lv_cnt_q) >= 6'(`LEVEL_EN_WAIT));
    endproperty
    a_lv_oe: assert property (p_lv_oe)
        else $error("feedback driven too early");

    property p_lv_fb;
        @(posedge LINK_CK_I) disable iff (RST_I)
        lv_st_q == LV_ACT && lv_en && str_rise |=> fb_q == $past(lk_s2_q[0]);
    endproperty
    a_lv_fb: assert property (p_lv_fb)
        else $error("feedback does not match sampled clock");

    property p_term_async;
        @(posedge CLOCK_I) disable iff (RST_I)
        t_pd && t_req != term_on_q |=> term_on_q == $past(t_req);
    endproperty
    a_term_async: assert property (p_term_async)
        else $error("termination did not switch in power-down");

    property p_ref_busy;
        @(posedge CLOCK_I) disable iff (RST_I)
        ref_rise && r_mode == REF_NORMAL |=> rbusy_q ##17 rbusy_q;
    endproperty
    a_ref_busy: assert property (p_ref_busy)
        else $error("refresh busy window too short");
endmodule : alert_timing_core
`default_nettype wire

// ===== test/ctrl_model.sv
// Controller-side model driving the link-domain inputs
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
    input  wire logic link_ck_i,
    output logic      par_err_o,
    output logic      crc_err_o,
    output logic      level_en_o,
    output logic      dqs_o,
    output logic      ck_lvl_o
);
    initial
    begin
        par_err_o  = 1'b0;
        crc_err_o  = 1'b0;
        level_en_o = 1'b0;
        dqs_o      = 1'b0;
        ck_lvl_o   = 1'b0;
    end

    // Two link cycles wide so the two-stage sync cannot miss it;
    // the caller waits out the alert before the next error
    // Only deselects follow an error while its alert stands
    task automatic err_pulse(input bit crc);
    begin
        @(negedge link_ck_i);
        crc_err_o = crc;
        par_err_o = !crc;
        repeat (2) @(negedge link_ck_i);
        crc_err_o = 1'b0;
        par_err_o = 1'b0;
    end
    endtask : err_pulse

    // No strobe before 40 cycles, which also covers the 25
    task automatic level_enter(input bit en);
    begin
        @(negedge link_ck_i);
        level_en_o = en;
        repeat (41) @(negedge link_ck_i);
    end
    endtask : level_enter

    task automatic strobe(input bit lvl);
    begin
        @(negedge link_ck_i);
        ck_lvl_o = lvl;
        dqs_o    = 1'b1;
        repeat (2) @(negedge link_ck_i);
        dqs_o    = 1'b0;
        repeat (2) @(negedge link_ck_i);
    end
    endtask : strobe
endmodule : ctrl_model
`default_nettype wire

// ===== test/ddr4_alert_leveling_refresh_timing_test.sv
// Self-checking bench for the alert, leveling, termination and refresh block
`timescale 1ns/1ps
`default_nettype none
module ddr4_alert_leveling_refresh_timing_test;
    import alert_timing_pkg::*;
    logic      clk, rst, link_ck, par_err, crc_err, level_en, dqs, ck_lvl;
    logic      term_req, pd_frozen, term_wr_req, ref_cmd, sr_abort;
    ref_mode_t ref_mode;
    logic      alert_n, cmd_hold, fb, fb_oe, term_on, term_wr, ref_busy;
    err_src_t  err_src;
    int        n_mismatch = 0;
    int        tests_run  = 0;
    bit        t_on       = 1'b0;
    bit        t_wr       = 1'b0;

    alert_timing_core dut (.CLOCK_I(clk), .RST_I(rst), .LINK_CK_I(link_ck),
        .PAR_ERR_I(par_err), .CRC_ERR_I(crc_err), .LEVEL_EN_I(level_en),
        .DQS_I(dqs), .CK_LVL_I(ck_lvl), .TERM_REQ_I(term_req),
        .PD_FROZEN_I(pd_frozen), .TERM_WR_REQ_I(term_wr_req),
        .REF_CMD_I(ref_cmd), .SR_ABORT_I(sr_abort), .REF_MODE_I(ref_mode),
        .ALERT_N_O(alert_n), .CMD_HOLD_O(cmd_hold), .LEVEL_FB_O(fb),
        .LEVEL_FB_OE_O(fb_oe), .TERM_ON_O(term_on), .TERM_WR_O(term_wr),
        .REF_BUSY_O(ref_busy), .ERR_SRC_O(err_src));

    ctrl_model ctl (.link_ck_i(link_ck), .par_err_o(par_err),
        .crc_err_o(crc_err), .level_en_o(level_en), .dqs_o(dqs),
        .ck_lvl_o(ck_lvl));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Odd offset keeps the link edges away from the system edges
    initial
    begin
        link_ck = 1'b0;
        #7;
        forever #40 link_ck = ~link_ck;
    end

    task automatic miss(input string msg);
    begin
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, msg);
    end
    endtask : miss

    task automatic results;
    begin
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask : results

    // Counts link cycles from the error pin rising to the alert edges
    task automatic alarm(input bit crc, input int e_first, e_low, e_hold);
        int first;
        int low;
        int hold;
    begin
        first = -1;
        low   = 0;
        hold  = 0;
        fork
            ctl.err_pulse(crc);
            begin
                @(negedge link_ck);
                for (int n = 1; n < 110; n++)
                begin
                    @(negedge link_ck);
                    if (alert_n === 1'b0 && first < 0)
                        first = n;
                    low  += (alert_n === 1'b0);
                    hold += (cmd_hold === 1'b1);
                    if (n == e_first + 2)
                    begin
                        tests_run++;
                        if (err_src !== {!crc, crc})
                            miss("alert source");
                    end
                end
            end
        join
        tests_run += 3;
        if (first != e_first)
            miss("alert delay");
        if (low != e_low)
            miss("alert width");
        if (hold != e_hold)
            miss("command hold window");
    end
    endtask : alarm

    task automatic leveling;
    begin
        ctl.level_enter(1'b1);
        tests_run++;
        if (fb_oe !== 1'b1)
            miss("feedback enable");
        ctl.strobe(1'b1);
        tests_run++;
        if (fb !== 1'b1)
            miss("feedback high");
        ctl.strobe(1'b0);
        tests_run++;
        if (fb !== 1'b0)
            miss("feedback low");
        ctl.level_enter(1'b0);
        tests_run++;
        if (fb_oe !== 1'b0)
            miss("feedback released");
    end
    endtask : leveling

    // Old value one cycle on, new value once sync and update are through
    task automatic term_case(input bit pd, input bit on, input bit wr);
    begin
        @(negedge clk);
        pd_frozen   = pd;
        term_req    = on;
        term_wr_req = wr;
        @(negedge clk);
        tests_run++;
        if (term_on !== t_on || term_wr !== t_wr)
            miss("termination early");
        t_on = on;
        t_wr = wr && !pd;
        repeat (3) @(negedge clk);
        tests_run += 2;
        if (term_on !== t_on)
            miss("termination on");
        if (term_wr !== t_wr)
            miss("write termination");
    end
    endtask : term_case

    task automatic refresh(input ref_mode_t m, input bit ab, input int exp);
        int busy;
    begin
        busy = 0;
        @(negedge clk);
        ref_mode = m;
        // Mode settles a cycle before the edge that samples it
        @(negedge clk);
        ref_cmd  = !ab;
        sr_abort = ab;
        for (int n = 0; n < 40; n++)
        begin
            @(negedge clk);
            busy += (ref_busy === 1'b1);
            if (n == 2)
            begin
                ref_cmd  = 1'b0;
                sr_abort = 1'b0;
            end
        end
        tests_run++;
        if (busy != exp)
            miss("refresh spacing");
    end
    endtask : refresh

    initial
    begin
        #1ms;
        miss("timeout");
        results();
    end

    initial
    begin
        rst         = 1'b1;
        term_req    = 1'b0;
        pd_frozen   = 1'b0;
        term_wr_req = 1'b0;
        ref_cmd     = 1'b0;
        sr_abort    = 1'b0;
        ref_mode    = REF_NORMAL;
        // Reset is asynchronous; one link edge inside it clears any X
        repeat (3) @(negedge clk);
        tests_run++;
        if (alert_n !== 1'b1 || cmd_hold !== 1'b0)
            miss("reset state");
        rst = 1'b0;
        alarm(1'b0, 6, 72, 4);
        alarm(1'b1, 3, 8, 0);
        leveling();
        term_case(1'b0, 1'b1, 1'b1);
        term_case(1'b1, 1'b0, 1'b1);
        term_case(1'b1, 1'b1, 1'b0);
        term_case(1'b0, 1'b0, 1'b0);
        refresh(REF_NORMAL, 1'b0, 18);
        refresh(REF_DOUBLE, 1'b0, 13);
        refresh(REF_QUAD, 1'b0, 8);
        refresh(REF_RSVD, 1'b0, 18);
        refresh(REF_NORMAL, 1'b1, 9);
        results();
    end
endmodule : ddr4_alert_leveling_refresh_timing_test
`default_nettype wire
